// File: core/sipd_pkg.sv
package sipd_pkg;

  localparam logic [7:0] BYTE_LOCK = 8'hf0;
  localparam logic [7:0] BYTE_ASZ = 8'h67;
  localparam logic [7:0] BYTE_OSZ = 8'h66;
  localparam logic [7:0] BYTE_REPNE = 8'hf2;
  localparam logic [7:0] BYTE_REP = 8'hf3;
  localparam logic [7:0] BYTE_HINT_A = 8'he2;
  localparam logic [7:0] BYTE_HINT_B = 8'he3;
  localparam logic [7:0] BYTE_ESC = 8'h0f;
  localparam logic [7:0] BYTE_SEG_ES = 8'h26;
  localparam logic [7:0] BYTE_SEG_CS = 8'h2e;
  localparam logic [7:0] BYTE_SEG_SS = 8'h36;
  localparam logic [7:0] BYTE_SEG_DS = 8'h3e;
  localparam logic [7:0] BYTE_SEG_FS = 8'h64;
  localparam logic [7:0] BYTE_SEG_GS = 8'h65;
  localparam logic [7:0] BYTE_NONE = 8'h00;
  localparam logic [3:0] EXT_PFX_HI = 4'h4;

  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int REG_HI = 5;
  localparam int REG_LO = 3;
  localparam int RM_HI = 2;
  localparam int RM_LO = 0;
  localparam int SCALE_HI = 7;
  localparam int SCALE_LO = 6;
  localparam int EXT_W = 3;
  localparam int EXT_R = 2;
  localparam int EXT_X = 1;
  localparam int EXT_B = 0;

  localparam logic [1:0] MOD_MEM0 = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISPW = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_SIB = 3'h4;
  localparam logic [2:0] RM_DISP_ONLY = 3'h5;
  localparam logic [2:0] RM16_DISP_ONLY = 3'h6;

  localparam logic [2:0] DISP_NONE = 3'h0;
  localparam logic [2:0] DISP_B1 = 3'h1;
  localparam logic [2:0] DISP_B2 = 3'h2;
  localparam logic [2:0] DISP_B4 = 3'h4;

  localparam int CAUSE_ASZ = 0;
  localparam int CAUSE_SEG = 1;
  localparam int CAUSE_OSZ = 2;
  localparam int CAUSE_REP = 3;
  localparam int CAUSE_HINT = 4;
  localparam int CAUSE_W = 5;

  typedef enum logic [1:0] {MODE_PROT, MODE_COMPAT, MODE_LONG64} sipd_mode_t;
  typedef enum logic [1:0] {AW_16, AW_32, AW_64} sipd_aw_t;
  typedef enum logic [2:0] {SEG_DEF, SEG_ES, SEG_CS, SEG_SS, SEG_DS, SEG_FS, SEG_GS} sipd_seg_t;
  typedef enum logic [1:0] {MAND_NONE, MAND_66, MAND_F2, MAND_F3} sipd_mand_t;
  typedef enum logic [3:0] {
    PFX_NONE, PFX_LOCK, PFX_ASZ, PFX_OSZ, PFX_REPNE, PFX_REP, PFX_SEG, PFX_HINT, PFX_EXT, PFX_ESC
  } sipd_pfx_t;

  function automatic logic [3:0] ext_idx(input logic ext, input logic [2:0] fld, input logic en);
    ext_idx = {ext & en, fld};
  endfunction

endpackage

// File: core/sipd_pfx_class.sv
`timescale 1ns/1ns
module sipd_pfx_class (
  input wire logic [7:0] i_byte,
  input wire sipd_pkg::sipd_mode_t i_mode,
  output sipd_pkg::sipd_pfx_t o_class,
  output sipd_pkg::sipd_seg_t o_seg
);

  always_comb
  begin
    o_seg = sipd_pkg::SEG_DEF;
    o_class = sipd_pkg::PFX_NONE;
    // The extension prefix exists only in 64-bit mode; elsewhere these bytes are ordinary opcodes.
    if (i_mode == sipd_pkg::MODE_LONG64 && i_byte[7:4] == sipd_pkg::EXT_PFX_HI)
    begin
      o_class = sipd_pkg::PFX_EXT;
    end
    else
    begin
      case (i_byte)
        sipd_pkg::BYTE_LOCK: o_class = sipd_pkg::PFX_LOCK;
        sipd_pkg::BYTE_ASZ: o_class = sipd_pkg::PFX_ASZ;
        sipd_pkg::BYTE_OSZ: o_class = sipd_pkg::PFX_OSZ;
        sipd_pkg::BYTE_REPNE: o_class = sipd_pkg::PFX_REPNE;
        sipd_pkg::BYTE_REP: o_class = sipd_pkg::PFX_REP;
        sipd_pkg::BYTE_HINT_A, sipd_pkg::BYTE_HINT_B: o_class = sipd_pkg::PFX_HINT;
        sipd_pkg::BYTE_ESC: o_class = sipd_pkg::PFX_ESC;
        sipd_pkg::BYTE_SEG_ES:
        begin
          o_class = sipd_pkg::PFX_SEG;
          o_seg = sipd_pkg::SEG_ES;
        end
        sipd_pkg::BYTE_SEG_CS:
        begin
          o_class = sipd_pkg::PFX_SEG;
          o_seg = sipd_pkg::SEG_CS;
        end
        sipd_pkg::BYTE_SEG_SS:
        begin
          o_class = sipd_pkg::PFX_SEG;
          o_seg = sipd_pkg::SEG_SS;
        end
        sipd_pkg::BYTE_SEG_DS:
        begin
          o_class = sipd_pkg::PFX_SEG;
          o_seg = sipd_pkg::SEG_DS;
        end
        sipd_pkg::BYTE_SEG_FS:
        begin
          o_class = sipd_pkg::PFX_SEG;
          o_seg = sipd_pkg::SEG_FS;
        end
        sipd_pkg::BYTE_SEG_GS:
        begin
          o_class = sipd_pkg::PFX_SEG;
          o_seg = sipd_pkg::SEG_GS;
        end
        default: o_class = sipd_pkg::PFX_NONE;
      endcase
    end
  end

endmodule

// File: core/sipd_form_decode.sv
`timescale 1ns/1ns
module sipd_form_decode (
  input wire logic [7:0] i_form,
  input wire logic [7:0] i_sib,
  input wire sipd_pkg::sipd_aw_t i_aw,
  output logic o_has_mem,
  output logic o_has_sib,
  output logic [2:0] o_disp_len
);

  logic [1:0] md;
  logic [2:0] rm;

  assign md = i_form[sipd_pkg::MOD_HI:sipd_pkg::MOD_LO];
  assign rm = i_form[sipd_pkg::RM_HI:sipd_pkg::RM_LO];

  // Same address encoding as the general instructions; i_sib only matters when o_has_sib is set.
  always_comb
  begin
    o_has_mem = (md != sipd_pkg::MOD_REG); // [RULE_14]
    o_has_sib = 1'b0;
    o_disp_len = sipd_pkg::DISP_NONE;
    if (i_aw == sipd_pkg::AW_16)
    begin
      if (md == sipd_pkg::MOD_DISP8)
        o_disp_len = sipd_pkg::DISP_B1;
      else if (md == sipd_pkg::MOD_DISPW || (md == sipd_pkg::MOD_MEM0 && rm == sipd_pkg::RM16_DISP_ONLY))
        o_disp_len = sipd_pkg::DISP_B2;
    end
    else
    begin
      o_has_sib = o_has_mem && rm == sipd_pkg::RM_SIB; // [RULE_13]
      if (md == sipd_pkg::MOD_DISP8)
        o_disp_len = sipd_pkg::DISP_B1;
      else if (md == sipd_pkg::MOD_DISPW || (md == sipd_pkg::MOD_MEM0 && rm == sipd_pkg::RM_DISP_ONLY))
        o_disp_len = sipd_pkg::DISP_B4;
      else if (md == sipd_pkg::MOD_MEM0 && o_has_sib && i_sib[2:0] == sipd_pkg::RM_DISP_ONLY)
        o_disp_len = sipd_pkg::DISP_B4;
    end
  end

endmodule

// File: core/sipd_decode.sv
// Functional notes
// [RULE_01] A lock prefix in front of any vector instruction always ends in the invalid opcode fault.
// [RULE_02] An address size prefix changes the address width with a memory operand and is reserved without one.
// [RULE_03] A segment override selects the operand segment with a memory operand and is reserved without one.
// [RULE_04] An operand size prefix that is not the mandatory prefix is reserved.
// [RULE_05] A repeat prefix that is not the mandatory prefix is reserved.
// [RULE_06] Branch hint prefixes in front of a vector instruction are reserved.
// [RULE_07] Mandatory prefix, escape byte and opcode byte form one opcode, the prefix being part of it.
// [RULE_08] A reserved combination either passes flagged or faults, chosen by a strap input per generation.
// [RULE_09] In 64-bit mode the extension prefix adds a fourth register index bit, giving sixteen registers.
// [RULE_10] The operand width flag of the extension prefix selects 64-bit general-purpose operands.
// [RULE_11] An extension prefix without meaning is ignored and never faults.
// [RULE_12] Compatibility mode decodes exactly like protected mode, with no extra registers.
// [RULE_13] Memory addresses come from the operand form byte and optional scaled index byte as usual.
// [RULE_14] An instruction has a memory operand when the mode field is not register-direct.
`timescale 1ns/1ns
module sipd_decode (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire sipd_pkg::sipd_mode_t i_mode,
  input wire logic i_cs_def32,
  input wire logic i_rsvd_fault_sel,
  output logic o_insn_valid,
  output logic o_not_vector,
  output logic o_invalid_opcode_fault,
  output logic [23:0] o_opcode,
  output logic o_has_mem,
  output sipd_pkg::sipd_aw_t o_addr_width,
  output sipd_pkg::sipd_seg_t o_seg,
  output logic [3:0] o_reg_idx,
  output logic [3:0] o_rm_idx,
  output logic o_has_sib,
  output logic [1:0] o_scale,
  output logic [3:0] o_index_idx,
  output logic [3:0] o_base_idx,
  output logic [2:0] o_disp_len,
  output logic [31:0] o_disp,
  output logic o_op64,
  output logic [sipd_pkg::CAUSE_W-1:0] o_rsvd_cause
);

  typedef enum logic [2:0] {ST_PFX, ST_OPC, ST_FORM, ST_SIB, ST_DISP} sipd_state_t;

  sipd_state_t state_r;
  logic lock_r;
  logic asz_r;
  logic hint_r;
  logic osz_extra_r;
  logic rep_extra_r;
  logic ext_seen_r;
  logic [3:0] ext_r;
  sipd_pkg::sipd_seg_t seg_r;
  sipd_pkg::sipd_mand_t mand_r;
  logic [7:0] op_r;
  logic [7:0] form_r;
  logic [7:0] sib_r;
  logic has_mem_r;
  logic has_sib_r;
  logic [2:0] disp_len_r;
  logic [2:0] disp_cnt_r;
  logic [31:0] disp_r;

  sipd_pkg::sipd_pfx_t pc_class;
  sipd_pkg::sipd_seg_t pc_seg;
  logic fd_has_mem;
  logic fd_has_sib;
  logic [2:0] fd_disp_len;
  logic [7:0] fd_form;
  sipd_pkg::sipd_aw_t aw_cur;
  logic ext_en;
  logic fin;
  logic non_vec;
  logic mem_now;
  logic [7:0] form_now;
  logic [7:0] sib_now;
  logic [2:0] disp_len_now;
  logic [31:0] disp_now;
  logic [sipd_pkg::CAUSE_W-1:0] cause_now;

  // Mandatory prefix expressed back as the byte it came from.
  function automatic logic [7:0] mand_byte(input sipd_pkg::sipd_mand_t m);
    unique case (m)
      sipd_pkg::MAND_66: mand_byte = sipd_pkg::BYTE_OSZ;
      sipd_pkg::MAND_F2: mand_byte = sipd_pkg::BYTE_REPNE;
      sipd_pkg::MAND_F3: mand_byte = sipd_pkg::BYTE_REP;
      sipd_pkg::MAND_NONE: mand_byte = sipd_pkg::BYTE_NONE;
    endcase
  endfunction

  sipd_pfx_class u_pfx_class (
    .i_byte(i_byte),
    .i_mode(i_mode),
    .o_class(pc_class),
    .o_seg(pc_seg)
  );

  // One decoder serves both the operand form byte and, one byte later, the scaled index byte.
  assign fd_form = (state_r == ST_FORM) ? i_byte : form_r;

  sipd_form_decode u_form_decode (
    .i_form(fd_form),
    .i_sib(i_byte),
    .i_aw(aw_cur),
    .o_has_mem(fd_has_mem),
    .o_has_sib(fd_has_sib),
    .o_disp_len(fd_disp_len)
  );

  always_comb
  begin
    // Protected and compatibility mode share one path: default width from the code segment.
    if (i_mode == sipd_pkg::MODE_LONG64) // [RULE_12]
      aw_cur = asz_r ? sipd_pkg::AW_32 : sipd_pkg::AW_64; // [RULE_02]
    else if (i_cs_def32 ^ asz_r)
      aw_cur = sipd_pkg::AW_32;
    else
      aw_cur = sipd_pkg::AW_16;
  end

  // Extension bits count only in 64-bit mode; elsewhere the upper registers cannot be reached.
  assign ext_en = (i_mode == sipd_pkg::MODE_LONG64) && ext_seen_r; // [RULE_09] [RULE_12]

  assign non_vec = i_byte_valid && state_r == ST_PFX && pc_class == sipd_pkg::PFX_NONE;

  always_comb
  begin
    fin = 1'b0;
    if (i_byte_valid)
    begin
      unique case (state_r)
        ST_FORM: fin = !fd_has_sib && fd_disp_len == sipd_pkg::DISP_NONE;
        ST_SIB: fin = fd_disp_len == sipd_pkg::DISP_NONE;
        ST_DISP: fin = (disp_cnt_r + 3'h1) == disp_len_r;
        ST_PFX, ST_OPC: fin = 1'b0;
      endcase
    end
  end

  assign mem_now = (state_r == ST_FORM) ? fd_has_mem : has_mem_r; // [RULE_14]
  assign form_now = (state_r == ST_FORM) ? i_byte : form_r;
  assign sib_now = (state_r == ST_SIB) ? i_byte : sib_r;
  assign disp_len_now = (state_r == ST_DISP) ? disp_len_r : fd_disp_len;
  assign disp_now = (state_r == ST_DISP) ? (disp_r | ({24'h0, i_byte} << {disp_cnt_r, 3'h0})) : 32'h0;

  always_comb
  begin
    cause_now = '0;
    cause_now[sipd_pkg::CAUSE_ASZ] = asz_r && !mem_now; // [RULE_02]
    cause_now[sipd_pkg::CAUSE_SEG] = (seg_r != sipd_pkg::SEG_DEF) && !mem_now; // [RULE_03]
    cause_now[sipd_pkg::CAUSE_OSZ] = osz_extra_r; // [RULE_04]
    cause_now[sipd_pkg::CAUSE_REP] = rep_extra_r; // [RULE_05]
    cause_now[sipd_pkg::CAUSE_HINT] = hint_r; // [RULE_06]
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      state_r <= ST_PFX;
    else if (i_byte_valid)
    begin
      unique case (state_r)
        ST_PFX: if (pc_class == sipd_pkg::PFX_ESC) state_r <= ST_OPC;
        ST_OPC: state_r <= ST_FORM;
        ST_FORM:
        begin
          if (fd_has_sib)
            state_r <= ST_SIB;
          else if (fd_disp_len != sipd_pkg::DISP_NONE)
            state_r <= ST_DISP;
          else
            state_r <= ST_PFX;
        end
        ST_SIB: state_r <= (fd_disp_len != sipd_pkg::DISP_NONE) ? ST_DISP : ST_PFX;
        ST_DISP: if (fin) state_r <= ST_PFX;
      endcase
    end
  end

  // Prefix collection; a new instruction starts clean after the previous one ends.
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || fin || non_vec)
    begin
      lock_r <= 1'b0;
      asz_r <= 1'b0;
      hint_r <= 1'b0;
      osz_extra_r <= 1'b0;
      rep_extra_r <= 1'b0;
      ext_seen_r <= 1'b0;
      ext_r <= 4'h0;
      seg_r <= sipd_pkg::SEG_DEF;
      mand_r <= sipd_pkg::MAND_NONE;
    end
    else if (i_byte_valid && state_r == ST_PFX && pc_class != sipd_pkg::PFX_ESC)
    begin
      // An extension prefix only counts when it is the last prefix before the escape.
      ext_seen_r <= (pc_class == sipd_pkg::PFX_EXT); // [RULE_11]
      ext_r <= (pc_class == sipd_pkg::PFX_EXT) ? i_byte[3:0] : 4'h0; // [RULE_11]
      unique case (pc_class)
        sipd_pkg::PFX_LOCK: lock_r <= 1'b1; // [RULE_01]
        sipd_pkg::PFX_ASZ: asz_r <= 1'b1;
        sipd_pkg::PFX_HINT: hint_r <= 1'b1;
        sipd_pkg::PFX_SEG: seg_r <= pc_seg; // [RULE_03]
        sipd_pkg::PFX_OSZ, sipd_pkg::PFX_REPNE, sipd_pkg::PFX_REP:
        begin
          // The last of these bytes is the mandatory one; an earlier one falls back to reserved.
          if (mand_r == sipd_pkg::MAND_66)
            osz_extra_r <= 1'b1; // [RULE_04]
          else if (mand_r != sipd_pkg::MAND_NONE)
            rep_extra_r <= 1'b1; // [RULE_05]
          if (pc_class == sipd_pkg::PFX_OSZ)
            mand_r <= sipd_pkg::MAND_66; // [RULE_07]
          else if (pc_class == sipd_pkg::PFX_REPNE)
            mand_r <= sipd_pkg::MAND_F2;
          else
            mand_r <= sipd_pkg::MAND_F3;
        end
        default: lock_r <= lock_r;
      endcase
    end
  end

  // Opcode and addressing bytes.
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      op_r <= 8'h00;
      form_r <= 8'h00;
      sib_r <= 8'h00;
      has_mem_r <= 1'b0;
      has_sib_r <= 1'b0;
      disp_len_r <= sipd_pkg::DISP_NONE;
      disp_cnt_r <= 3'h0;
      disp_r <= 32'h0;
    end
    else if (i_byte_valid)
    begin
      unique case (state_r)
        ST_OPC: op_r <= i_byte; // [RULE_07]
        ST_FORM:
        begin
          form_r <= i_byte; // [RULE_13]
          sib_r <= 8'h00;
          has_mem_r <= fd_has_mem;
          has_sib_r <= fd_has_sib;
          disp_len_r <= fd_disp_len;
          disp_cnt_r <= 3'h0;
          disp_r <= 32'h0;
        end
        ST_SIB:
        begin
          sib_r <= i_byte; // [RULE_13]
          disp_len_r <= fd_disp_len;
        end
        ST_DISP:
        begin
          disp_r <= disp_now;
          disp_cnt_r <= disp_cnt_r + 3'h1;
        end
        ST_PFX: disp_cnt_r <= 3'h0;
      endcase
    end
  end

  // Result outputs; apart from the two pulse flags and the fault clearing on a non-vector byte, they change only when an instruction completes.
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_insn_valid <= 1'b0;
      o_not_vector <= 1'b0;
      o_invalid_opcode_fault <= 1'b0;
      o_opcode <= 24'h0;
      o_has_mem <= 1'b0;
      o_addr_width <= sipd_pkg::AW_32;
      o_seg <= sipd_pkg::SEG_DEF;
      o_reg_idx <= 4'h0;
      o_rm_idx <= 4'h0;
      o_has_sib <= 1'b0;
      o_scale <= 2'h0;
      o_index_idx <= 4'h0;
      o_base_idx <= 4'h0;
      o_disp_len <= sipd_pkg::DISP_NONE;
      o_disp <= 32'h0;
      o_op64 <= 1'b0;
      o_rsvd_cause <= '0;
    end
    else
    begin
      o_insn_valid <= fin;
      o_not_vector <= non_vec;
      if (fin)
      begin
        o_invalid_opcode_fault <= lock_r || (i_rsvd_fault_sel && (|cause_now)); // [RULE_01] [RULE_08]
        o_rsvd_cause <= cause_now; // [RULE_08]
        o_opcode <= {mand_byte(mand_r), sipd_pkg::BYTE_ESC, op_r}; // [RULE_07]
        o_has_mem <= mem_now;
        o_addr_width <= aw_cur; // [RULE_02]
        o_seg <= mem_now ? seg_r : sipd_pkg::SEG_DEF; // [RULE_03]
        o_reg_idx <= sipd_pkg::ext_idx(ext_r[sipd_pkg::EXT_R], form_now[sipd_pkg::REG_HI:sipd_pkg::REG_LO],
          ext_en); // [RULE_09]
        o_rm_idx <= sipd_pkg::ext_idx(ext_r[sipd_pkg::EXT_B], form_now[sipd_pkg::RM_HI:sipd_pkg::RM_LO],
          ext_en); // [RULE_09]
        o_has_sib <= (state_r == ST_FORM) ? 1'b0 : has_sib_r;
        o_scale <= sib_now[sipd_pkg::SCALE_HI:sipd_pkg::SCALE_LO];
        o_index_idx <= sipd_pkg::ext_idx(ext_r[sipd_pkg::EXT_X], sib_now[5:3], ext_en); // [RULE_13]
        o_base_idx <= sipd_pkg::ext_idx(ext_r[sipd_pkg::EXT_B], sib_now[2:0], ext_en); // [RULE_13]
        o_disp_len <= disp_len_now;
        o_disp <= disp_now;
        o_op64 <= ext_en && ext_r[sipd_pkg::EXT_W]; // [RULE_10]
      end
      else if (non_vec)
        o_invalid_opcode_fault <= 1'b0;
    end
  end

endmodule

// File: sim/sipd_fetch_model.sv
`timescale 1ns/1ns
module sipd_fetch_model (
  input wire logic i_core_clk,
  output logic o_byte_valid,
  output logic [7:0] o_byte
);
  initial
  begin
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
  end

  // An idle lane inverts the byte lane on every idle cycle, so a decoder that samples it
  // outside a valid cycle picks up changing garbage rather than a steady repeat.
  task automatic idle();
    @(negedge i_core_clk);
    o_byte_valid = 1'b0;
    o_byte = ~o_byte;
  endtask

  // A gap above zero models a slow fetch stage that starves the decoder.
  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap) idle();
    @(negedge i_core_clk);
    o_byte_valid = 1'b1;
    o_byte = b;
  endtask
endmodule

// File: sim/sipd_decode_assertions.sv
`timescale 1ns/1ns
module sipd_decode_assertions (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire sipd_pkg::sipd_mode_t i_mode,
  input wire logic i_rsvd_fault_sel,
  input wire logic o_insn_valid,
  input wire logic o_not_vector,
  input wire logic o_invalid_opcode_fault,
  input wire logic [23:0] o_opcode,
  input wire logic o_has_mem,
  input wire sipd_pkg::sipd_aw_t o_addr_width,
  input wire sipd_pkg::sipd_seg_t o_seg,
  input wire logic [3:0] o_reg_idx,
  input wire logic [3:0] o_rm_idx,
  input wire logic o_has_sib,
  input wire logic [2:0] o_disp_len,
  input wire logic o_op64,
  input wire logic [sipd_pkg::CAUSE_W-1:0] o_rsvd_cause
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_lock_insn;
    i_byte_valid && i_byte == sipd_pkg::BYTE_LOCK ##1 i_byte_valid && i_byte == sipd_pkg::BYTE_ESC
      ##1 i_byte_valid ##1 i_byte_valid && i_byte[7:6] == sipd_pkg::MOD_REG;
  endsequence
  sequence s_done;
    o_insn_valid;
  endsequence

  property p_lock;
    s_lock_insn |=> s_done and o_invalid_opcode_fault;
  endproperty
  a_lock: assert property (p_lock) else $error("lock prefix did not fault");
  property p_answer;
    s_done |-> $past(i_byte_valid);
  endproperty
  a_answer: assert property (p_answer) else $error("completion without a byte taken");
  property p_single;
    s_done |-> !o_not_vector ##1 !o_insn_valid;
  endproperty
  a_single: assert property (p_single) else $error("completion pulse too long");
  // The reset guard lets a one-edge reset clear the results without a false report.
  property p_stand;
    !o_insn_valid && !o_not_vector && !$past(i_sys_rst) |-> $stable(o_opcode) && $stable(o_has_mem) && $stable(o_seg);
  endproperty
  a_stand: assert property (p_stand) else $error("result changed between completions");
  // The mode that counts is the one at the completing edge, one cycle before the pulse is seen.
  property p_mode;
    s_done and $past(i_mode) != sipd_pkg::MODE_LONG64 |->
      !o_reg_idx[3] && !o_rm_idx[3] && !o_op64 && o_addr_width != sipd_pkg::AW_64;
  endproperty
  a_mode: assert property (p_mode) else $error("extended state outside 64-bit mode");
  property p_nomem;
    o_insn_valid && !o_has_mem |-> o_seg == sipd_pkg::SEG_DEF && o_disp_len == sipd_pkg::DISP_NONE && !o_has_sib;
  endproperty
  a_nomem: assert property (p_nomem) else $error("address fields on register form");
  property p_mem_pfx;
    o_insn_valid && o_has_mem |-> !o_rsvd_cause[sipd_pkg::CAUSE_ASZ] && !o_rsvd_cause[sipd_pkg::CAUSE_SEG];
  endproperty
  a_mem_pfx: assert property (p_mem_pfx) else $error("memory prefix reported reserved");
  property p_strap;
    o_insn_valid && o_rsvd_cause != 5'h00 && $past(i_rsvd_fault_sel) |-> o_invalid_opcode_fault;
  endproperty
  a_strap: assert property (p_strap) else $error("reserved combination did not fault");
  property p_clear;
    o_not_vector |-> !o_invalid_opcode_fault && $past(i_byte_valid);
  endproperty
  a_clear: assert property (p_clear) else $error("dropped byte left a fault");
  property p_aw16;
    o_insn_valid && o_addr_width == sipd_pkg::AW_16 |-> !o_has_sib && o_disp_len != sipd_pkg::DISP_B4;
  endproperty
  a_aw16: assert property (p_aw16) else $error("bad 16-bit address form");
endmodule

// File: sim/test_simd_prefix_decode.sv
`timescale 1ns/1ns
module test_simd_prefix_decode;
  logic i_core_clk;
  logic i_sys_rst;
  logic i_byte_valid;
  logic [7:0] i_byte;
  sipd_pkg::sipd_mode_t i_mode;
  logic i_cs_def32;
  logic i_rsvd_fault_sel;
  logic o_insn_valid;
  logic o_not_vector;
  logic o_invalid_opcode_fault;
  logic [23:0] o_opcode;
  logic o_has_mem;
  sipd_pkg::sipd_aw_t o_addr_width;
  sipd_pkg::sipd_seg_t o_seg;
  logic [3:0] o_reg_idx;
  logic [3:0] o_rm_idx;
  logic o_has_sib;
  logic [1:0] o_scale;
  logic [3:0] o_index_idx;
  logic [3:0] o_base_idx;
  logic [2:0] o_disp_len;
  logic [31:0] o_disp;
  logic o_op64;
  logic [sipd_pkg::CAUSE_W-1:0] o_rsvd_cause;
  int error_cnt;
  int cmp_count;

  sipd_fetch_model sipd_fetch_model_i (.i_core_clk(i_core_clk), .o_byte_valid(i_byte_valid), .o_byte(i_byte));
  sipd_decode sipd_decode_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_byte_valid(i_byte_valid),
    .i_byte(i_byte), .i_mode(i_mode), .i_cs_def32(i_cs_def32), .i_rsvd_fault_sel(i_rsvd_fault_sel),
    .o_insn_valid(o_insn_valid), .o_not_vector(o_not_vector), .o_invalid_opcode_fault(o_invalid_opcode_fault),
    .o_opcode(o_opcode), .o_has_mem(o_has_mem), .o_addr_width(o_addr_width), .o_seg(o_seg),
    .o_reg_idx(o_reg_idx), .o_rm_idx(o_rm_idx), .o_has_sib(o_has_sib), .o_scale(o_scale),
    .o_index_idx(o_index_idx), .o_base_idx(o_base_idx), .o_disp_len(o_disp_len), .o_disp(o_disp),
    .o_op64(o_op64), .o_rsvd_cause(o_rsvd_cause));

  initial
  begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    i_sys_rst = 1'b1;
    repeat (5) @(negedge i_core_clk);
    check("reset flags", 32'({o_insn_valid, o_not_vector, o_invalid_opcode_fault, o_has_mem, o_op64, o_has_sib,
      o_rsvd_cause, o_addr_width, o_seg}), 32'({11'h000, sipd_pkg::AW_32, sipd_pkg::SEG_DEF}));
    check("reset fields", {o_opcode, o_reg_idx, o_rm_idx} | o_disp, 32'h0);
    i_sys_rst = 1'b0;
  endtask

  // Bytes are right-aligned in seq with the first byte highest; no idle follows the last one.
  task automatic feed(input logic [63:0] seq, input int n, input int gap);
    for (int k = n - 1; k >= 0; k--)
      sipd_fetch_model_i.send(seq[8*k +: 8], gap);
  endtask

  // Returns in the cycle after the last byte was taken, where the completion pulse stands.
  task automatic issue(input logic [63:0] seq, input int n, input int gap);
    feed(seq, n, gap);
    sipd_fetch_model_i.idle();
  endtask

  task automatic expect_insn(input logic [23:0] op, input logic [4:0] cause, input logic fault);
    check("insn valid", 32'(o_insn_valid), 32'h1);
    check("opcode", 32'(o_opcode), 32'(op));
    check("cause", 32'(o_rsvd_cause), 32'(cause));
    check("fault", 32'(o_invalid_opcode_fault), 32'(fault));
  endtask

  task automatic t_mand_disp();
    i_mode = sipd_pkg::MODE_PROT;
    i_cs_def32 = 1'b1;
    i_rsvd_fault_sel = 1'b1;
    issue(64'hf30f100578563412, 8, 1);
    expect_insn(24'hf30f10, 5'h00, 1'b0);
    check("mem flag", 32'(o_has_mem), 32'h1);
    check("disp", o_disp, 32'h12345678);
    check("disp len", 32'({o_disp_len, o_addr_width}), 32'({sipd_pkg::DISP_B4, sipd_pkg::AW_32}));
  endtask

  // The lock instruction is followed at once by a non-vector byte, so the drop also clears the fault.
  task automatic t_lock();
    i_rsvd_fault_sel = 1'b0;
    feed(64'hf00f58c190, 5, 0);
    expect_insn(24'h000f58, 5'h00, 1'b1);
    check("mem flag", 32'(o_has_mem), 32'h0);
    sipd_fetch_model_i.idle();
    check("drop", 32'({o_not_vector, o_invalid_opcode_fault}), 32'h2);
  endtask

  task automatic t_rsvd();
    logic [39:0] seq [6] = '{40'h670f58c1, 40'h2e0f58c1, 40'h66f30f58c1, 40'hf2660f58c1, 40'he20f58c1, 40'he30f58c1};
    int len [6] = '{4, 4, 5, 5, 4, 4};
    logic [4:0] cause [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h10};
    logic [23:0] op [6] = '{24'h000f58, 24'h000f58, 24'hf30f58, 24'h660f58, 24'h000f58, 24'h000f58};
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 6; c++)
      begin
        i_rsvd_fault_sel = s[0];
        issue(64'(seq[c]), len[c], 0);
        expect_insn(op[c], cause[c], s[0]);
        check("seg", 32'(o_seg), 32'(sipd_pkg::SEG_DEF));
      end
  endtask

  task automatic t_mem_pfx();
    i_rsvd_fault_sel = 1'b1;
    issue(64'h67640f5800, 5, 0);
    expect_insn(24'h000f58, 5'h00, 1'b0);
    check("aw seg", 32'({o_addr_width, o_seg}), 32'({sipd_pkg::AW_16, sipd_pkg::SEG_FS}));
    i_cs_def32 = 1'b0;
    issue(64'h0f58863412, 5, 2);
    expect_insn(24'h000f58, 5'h00, 1'b0);
    check("disp16", 32'({o_disp_len, o_addr_width}), 32'({sipd_pkg::DISP_B2, sipd_pkg::AW_16}));
    check("disp", o_disp, 32'h00001234);
  endtask

  task automatic t_long();
    i_mode = sipd_pkg::MODE_LONG64;
    issue(64'h4d0f58c9, 4, 0);
    expect_insn(24'h000f58, 5'h00, 1'b0);
    check("ext regs", 32'({o_reg_idx, o_rm_idx, o_op64}), 32'h133);
    issue(64'h41660f58c1, 5, 0);
    expect_insn(24'h660f58, 5'h00, 1'b0);
    check("ext ignored", 32'({o_reg_idx, o_rm_idx, o_op64}), 32'h002);
    issue(64'h430f580488, 5, 0);
    expect_insn(24'h000f58, 5'h00, 1'b0);
    check("sib", 32'({o_has_sib, o_scale, o_index_idx, o_base_idx, o_disp_len, o_addr_width}),
      32'({1'b1, 2'h2, 4'h9, 4'h8, sipd_pkg::DISP_NONE, sipd_pkg::AW_64}));
  endtask

  task automatic t_compat();
    i_mode = sipd_pkg::MODE_COMPAT;
    i_cs_def32 = 1'b1;
    issue(64'h4d, 1, 0);
    check("no ext prefix", 32'(o_not_vector), 32'h1);
    issue(64'h0f58c9, 3, 0);
    expect_insn(24'h000f58, 5'h00, 1'b0);
    check("compat regs", 32'({o_reg_idx, o_rm_idx, o_op64, o_addr_width}),
      32'({4'h1, 4'h1, 1'b0, sipd_pkg::AW_32}));
  endtask

  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    i_sys_rst = 1'b1;
    i_mode = sipd_pkg::MODE_PROT;
    i_cs_def32 = 1'b1;
    i_rsvd_fault_sel = 1'b0;
    @(negedge i_core_clk);
    do_reset();
    t_mand_disp();
    t_lock();
    t_rsvd();
    t_mem_pfx();
    do_reset();
    t_long();
    t_compat();
    close_out();
  end

  initial
  begin
    repeat (3000) @(posedge i_core_clk);
    error_cnt++;
    close_out();
  end
endmodule

bind sipd_decode sipd_decode_assertions sipd_decode_assertions_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_byte_valid(i_byte_valid), .i_byte(i_byte), .i_mode(i_mode), .i_rsvd_fault_sel(i_rsvd_fault_sel),
  .o_insn_valid(o_insn_valid), .o_not_vector(o_not_vector), .o_invalid_opcode_fault(o_invalid_opcode_fault),
  .o_opcode(o_opcode), .o_has_mem(o_has_mem), .o_addr_width(o_addr_width), .o_seg(o_seg),
  .o_reg_idx(o_reg_idx), .o_rm_idx(o_rm_idx), .o_has_sib(o_has_sib), .o_disp_len(o_disp_len),
  .o_op64(o_op64), .o_rsvd_cause(o_rsvd_cause));
